//--- include/psc_pkg.sv
// package: constants and types for the protection stage control block
package psc_pkg;
  localparam int unsigned psc_clk_hz = 100_000_000;
  localparam int unsigned psc_groups = 4;
  localparam int unsigned psc_inputs = 16;
  localparam int unsigned psc_sel_w = 5;
  localparam int unsigned psc_meas_w = 16;
  localparam int unsigned psc_dly_w = 32;
  // panel inactivity time before the test force flag clears
  localparam int unsigned psc_force_timeout_s = 300;
  localparam longint unsigned psc_force_cycles = longint'(psc_force_timeout_s) * psc_clk_hz;
  // fault clearance detection bound, in ms
  localparam int unsigned psc_retard_ms = 50;
  localparam int unsigned psc_retard_cycles = psc_retard_ms * (psc_clk_hz / 1000);
  // reset delay upper bound, in ms
  localparam int unsigned psc_reset_max_ms = 95;
  localparam int unsigned psc_reset_max_cycles = psc_reset_max_ms * (psc_clk_hz / 1000);
  // reset values
  localparam logic [1:0] psc_group_rst = 2'h0;
  localparam logic [psc_dly_w-1:0] psc_cnt_rst = 32'h0;
  // stage status, gray coded along idle -> start -> trip
  typedef enum logic [1:0] {
    psc_idle = 2'b00,
    psc_start = 2'b01,
    psc_trip = 2'b11,
    psc_blocked = 2'b10
  } psc_state_e;
endpackage : psc_pkg

//--- rtl/psc_group_select.sv
// setting group selection from assigned digital or virtual inputs
`timescale 1ns/1ps
`default_nettype none
module psc_group_select (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [psc_pkg::psc_inputs-1:0] digital_input,
  input wire logic [3:0] virtual_input,
  input wire logic [4*psc_pkg::psc_sel_w-1:0] group_control_input_select,
  input wire logic [3:0] group_control_enable,
  input wire logic [1:0] default_group_select,
  input wire logic group_priority_order,
  output logic [1:0] active_group
);
  import psc_pkg::*;
  // combined source vector: digital inputs, then virtual inputs
  logic [psc_inputs+3:0] src;
  logic [3:0] req;
  logic [1:0] next_group;
  assign src = {virtual_input, digital_input};
  // one selector per group
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_sel
      logic [psc_sel_w-1:0] sel;
      assign sel = group_control_input_select[g*psc_sel_w +: psc_sel_w];
      // out of range selections read as inactive
      assign req[g] = group_control_enable[g] && (sel < psc_sel_w'(psc_inputs + 4))
                      && src[sel]; // RQ4 RQ5
    end
  endgenerate
  // priority resolution, default when nothing asserted
  always_comb begin
    next_group = default_group_select; // RQ2
    if (group_priority_order) begin
      // descending: highest number wins
      for (int i = 0; i < 4; i++) begin
        if (req[i]) next_group = 2'(i); // RQ3 RQ1
      end
    end else begin
      // ascending: lowest number wins
      for (int i = 3; i >= 0; i--) begin
        if (req[i]) next_group = 2'(i); // RQ3 RQ1
      end
    end
  end
  // registered so every stage parameter switches on one edge
  always_ff @(posedge core_clk) begin
    if (rst) active_group <= psc_group_rst;
    else active_group <= next_group; // RQ23
  end
endmodule // psc_group_select
`default_nettype wire

//--- rtl/psc_stage.sv
// protection stage control: groups, comparator, status machine, force flag
`timescale 1ns/1ps
`default_nettype none
// Function
// RQ1 - active group input selects its group
// RQ2 - no input active uses default group
// RQ3 - priority order resolves simultaneous group inputs
// RQ4 - four groups, each any digital input
// RQ5 - virtual inputs may select group
// RQ6 - status idle, blocked, start or trip
// RQ7 - start state counts operate delay
// RQ8 - trip holds while fault persists
// RQ9 - start output on fault detection
// RQ10 - trip after delay unless fault gone
// RQ11 - force flag clears after panel idle
// RQ12 - block input accepted by stage; the code ignores it on arc stages (arc_stage)
// RQ13 - blocked stage does not pick up
// RQ14 - blocking freezes operate delay counter
// RQ15 - block after trip has no effect
// RQ16 - fault clearance seen under 50 ms
// RQ17 - outputs release after reset delay unless latched
// RQ18 - reset delay below 95 ms; the code does not limit reset_delay to it
// RQ19 - comparators use hysteresis dead band
// RQ20 - start and trip routed to matrix
// RQ21 - current thresholds scaled by variant reference
// RQ22 - return to idle after reset delay
// RQ23 - group change switches all settings together
module psc_stage #(
  parameter longint unsigned force_cycles = psc_pkg::psc_force_cycles
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [psc_pkg::psc_inputs-1:0] digital_input,
  input wire logic [3:0] virtual_input,
  input wire logic [4*psc_pkg::psc_sel_w-1:0] group_control_input_select,
  input wire logic [3:0] group_control_enable,
  input wire logic [1:0] default_group_select,
  input wire logic group_priority_order,
  input wire logic [4*psc_pkg::psc_meas_w-1:0] pickup_pu,
  input wire logic [4*psc_pkg::psc_meas_w-1:0] hyst_pu,
  input wire logic [4*psc_pkg::psc_dly_w-1:0] operate_delay,
  input wire logic [4*psc_pkg::psc_dly_w-1:0] reset_delay,
  input wire logic [psc_pkg::psc_meas_w-1:0] measured,
  input wire logic [psc_pkg::psc_meas_w-1:0] motor_rated_current,
  input wire logic [psc_pkg::psc_meas_w-1:0] nominal_current,
  input wire logic motor_variant,
  input wire logic motor_only,
  input wire logic less_than,
  input wire logic arc_stage,
  input wire logic block_in,
  input wire logic latch_enable,
  input wire logic latch_release,
  input wire logic force_set,
  input wire logic force_start,
  input wire logic force_trip,
  input wire logic panel_button,
  output logic [1:0] active_group,
  output logic [1:0] stage_status,
  output logic start_out,
  output logic trip_out,
  output logic force_flag
);
  import psc_pkg::*;
  // two-flop synchronisers for pin-level inputs
  logic [psc_inputs-1:0] di_s1, di_s2;
  logic blk_s1, blk_s2, btn_s1, btn_s2, btn_d;
  // selected group settings
  logic [1:0] grp;
  logic [psc_meas_w-1:0] pickup, hyst;
  logic [psc_dly_w-1:0] op_dly, rst_dly;
  // scaled threshold and comparator
  logic [psc_meas_w-1:0] ref_cur;
  logic [2*psc_meas_w-1:0] thr_wide;
  logic [psc_meas_w-1:0] thr_on, thr_off;
  logic fault, next_fault, fault_q;
  logic blocked_eff;
  // status machine and counters
  psc_state_e state, next_state;
  logic [psc_dly_w-1:0] op_cnt, rs_cnt;
  logic releasing;
  logic latched;
  logic [63:0] idle_cnt;

  // synchronise digital inputs, block and panel button
  always_ff @(posedge core_clk) begin
    if (rst) begin
      di_s1 <= '0;
      di_s2 <= '0;
      blk_s1 <= 1'b0;
      blk_s2 <= 1'b0;
      btn_s1 <= 1'b0;
      btn_s2 <= 1'b0;
      btn_d <= 1'b0;
    end else begin
      di_s1 <= digital_input;
      di_s2 <= di_s1;
      blk_s1 <= block_in;
      blk_s2 <= blk_s1;
      btn_s1 <= panel_button;
      btn_s2 <= btn_s1;
      btn_d <= btn_s2;
    end
  end

  // group selection; registered group feeds every setting mux at once
  psc_group_select u_grp (
    .core_clk(core_clk),
    .rst(rst),
    .digital_input(di_s2),
    .virtual_input(virtual_input),
    .group_control_input_select(group_control_input_select),
    .group_control_enable(group_control_enable),
    .default_group_select(default_group_select),
    .group_priority_order(group_priority_order),
    .active_group(grp)
  );

  // setting mux from the single registered group index
  assign pickup = pickup_pu[grp*psc_meas_w +: psc_meas_w]; // RQ23
  assign hyst = hyst_pu[grp*psc_meas_w +: psc_meas_w]; // RQ23
  assign op_dly = operate_delay[grp*psc_dly_w +: psc_dly_w]; // RQ23
  assign rst_dly = reset_delay[grp*psc_dly_w +: psc_dly_w]; // RQ23

  // reference current: motor rating on motor builds or motor-only stages
  assign ref_cur = (motor_variant || motor_only) ? motor_rated_current
                                                 : nominal_current; // RQ21
  // pickup is per unit in 8.8 fixed point
  assign thr_wide = pickup * ref_cur; // RQ21
  assign thr_on = thr_wide[psc_meas_w+7:8];
  // dead band; saturate so the band never wraps
  always_comb begin
    if (less_than) begin
      thr_off = (thr_on > ~hyst) ? '1 : thr_on + hyst;
    end else begin
      thr_off = (thr_on < hyst) ? '0 : thr_on - hyst;
    end
  end

  // hysteresis comparator: pick up past threshold, drop out past the band
  always_comb begin
    next_fault = fault_q;
    if (less_than) begin
      if (measured < thr_on) next_fault = 1'b1; // RQ19
      else if (measured > thr_off) next_fault = 1'b0; // RQ19
    end else begin
      if (measured > thr_on) next_fault = 1'b1; // RQ19
      else if (measured < thr_off) next_fault = 1'b0; // RQ19
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) fault_q <= 1'b0;
    else fault_q <= next_fault;
  end

  // test forcing counts as a fault while the flag is set
  assign fault = fault_q || (force_flag && (force_start || force_trip));
  // arc stages ignore blocking
  assign blocked_eff = blk_s2 && !arc_stage; // RQ12
  assign releasing = (rs_cnt >= rst_dly); // RQ18

  // status transitions
  always_comb begin
    next_state = state;
    case (state)
      psc_idle: begin
        if (fault && blocked_eff) next_state = psc_blocked; // RQ13
        else if (fault) next_state = psc_start; // RQ9
      end
      psc_blocked: begin
        if (!fault) next_state = psc_idle;
        else if (!blocked_eff) next_state = psc_start; // RQ14
      end
      psc_start: begin
        if (!fault) next_state = psc_idle; // RQ10 RQ16
        else if (blocked_eff) next_state = psc_blocked; // RQ14
        else if ((op_cnt + 32'h1 >= op_dly) || (force_flag && force_trip))
          next_state = psc_trip; // RQ10
      end
      psc_trip: begin
        // block ignored here; leave only after reset delay and no latch
        if (!fault && releasing && !latched) next_state = psc_idle; // RQ8 RQ15 RQ17 RQ22
      end
      default: next_state = psc_idle;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) state <= psc_idle;
    else state <= next_state; // RQ6
  end

  // operate delay counter: runs in start, frozen while blocked
  always_ff @(posedge core_clk) begin
    if (rst) op_cnt <= psc_cnt_rst;
    else if (!fault) op_cnt <= psc_cnt_rst; // RQ14
    else if (state == psc_start && !blocked_eff) op_cnt <= op_cnt + 32'h1; // RQ7
  end

  // reset delay counter: runs after the fault clears in trip
  always_ff @(posedge core_clk) begin
    if (rst) rs_cnt <= psc_cnt_rst;
    else if (state != psc_trip || fault) rs_cnt <= psc_cnt_rst;
    else if (!releasing) rs_cnt <= rs_cnt + 32'h1; // RQ17
  end

  // latch arms only on entry to trip, so a release pulse is not re-armed at once
  always_ff @(posedge core_clk) begin
    if (rst) latched <= 1'b0;
    else if (next_state == psc_trip && state != psc_trip && latch_enable) latched <= 1'b1;
    else if (latch_release) latched <= 1'b0;
  end

  // registered outputs for the output matrix
  always_ff @(posedge core_clk) begin
    if (rst) begin
      start_out <= 1'b0;
      trip_out <= 1'b0;
      stage_status <= 2'h0;
      active_group <= psc_group_rst;
    end else begin
      start_out <= (next_state == psc_start) || (next_state == psc_trip); // RQ9 RQ20
      trip_out <= (next_state == psc_trip); // RQ10 RQ20
      stage_status <= next_state; // RQ6
      active_group <= grp;
    end
  end

  // force flag: set by request, cleared after panel inactivity
  always_ff @(posedge core_clk) begin
    if (rst) begin
      force_flag <= 1'b0;
      idle_cnt <= 64'h0;
    end else begin
      if (btn_s2 != btn_d || force_set) idle_cnt <= 64'h0;
      else if (force_flag) idle_cnt <= idle_cnt + 64'h1;
      if (force_set) force_flag <= 1'b1;
      else if (idle_cnt + 64'h1 >= force_cycles) force_flag <= 1'b0; // RQ11
    end
  end

  // checks
  chk_block_no_pickup: assert property (@(posedge core_clk) disable iff (rst)
    (state == psc_idle && blocked_eff && fault) |=> (state == psc_blocked)) // RQ13
    else $error("blocked fault must not start");
  chk_trip_ignores_block: assert property (@(posedge core_clk) disable iff (rst)
    (state == psc_trip && fault) |=> (state == psc_trip)) // RQ15
    else $error("trip left while fault present");
  chk_freeze_count: assert property (@(posedge core_clk) disable iff (rst)
    (state == psc_blocked && fault && $past(fault)) |-> $stable(op_cnt)) // RQ14
    else $error("delay counter moved while blocked");
  chk_trip_needs_fault: assert property (@(posedge core_clk) disable iff (rst)
    $rose(trip_out) |-> $past(fault)) // RQ10
    else $error("trip without fault");
  chk_start_follow: assert property (@(posedge core_clk) disable iff (rst)
    (state == psc_idle && fault && !blocked_eff) |=> start_out) // RQ9
    else $error("start not raised on fault");
  chk_clear_fast: assert property (@(posedge core_clk) disable iff (rst)
    (state == psc_start && !fault) |=> ##[0:2] (state == psc_idle)) // RQ16
    else $error("fault clearance not seen");
  chk_trip_implies_start: assert property (@(posedge core_clk) disable iff (rst)
    trip_out |-> start_out) // RQ20
    else $error("trip without start");
  chk_force_clear: assert property (@(posedge core_clk) disable iff (rst)
    (force_flag && !force_set && idle_cnt + 64'h1 >= force_cycles) |=> !force_flag) // RQ11
    else $error("force flag did not clear");
  chk_group_stable: assert property (@(posedge core_clk) disable iff (rst)
    active_group == $past(grp)) // RQ23
    else $error("group output mismatch");
endmodule // psc_stage
`default_nettype wire

//--- bench/psc_far_side.sv
// far side model: measurement source and binary input pins
`timescale 1ns/1ps
`default_nettype none
module psc_far_side (
  input wire logic core_clk,
  input wire logic fault_on,
  input wire logic [psc_pkg::psc_inputs-1:0] pins_req,
  output logic [psc_pkg::psc_meas_w-1:0] measured,
  output logic [psc_pkg::psc_inputs-1:0] digital_input
);
  import psc_pkg::*;
  // value well clear of the dead band either way, so noise plays no part
  always_ff @(posedge core_clk) begin
    measured <= fault_on ? 16'h0200 : 16'h0080;
  end
  // pins follow requests one clock late, like a contact
  always_ff @(posedge core_clk) begin
    digital_input <= pins_req;
  end
endmodule // psc_far_side
`default_nettype wire

//--- bench/protection_stage_control_tb_top.sv
// testbench for the protection stage control block
`timescale 1ns/1ps
`default_nettype none
module protection_stage_control_tb_top;
  import psc_pkg::*;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic fault_on = 1'b0;
  logic [15:0] pins_req = 16'h0;
  logic [15:0] measured;
  logic [15:0] digital_input;
  logic [3:0] vi = 4'h0;
  logic ord = 1'b0;
  logic block_in = 1'b0;
  logic force_set = 1'b0;
  logic panel_button = 1'b0;
  logic latch_enable = 1'b0;
  logic latch_release = 1'b0;
  // settings held in variables so scenarios may change them
  logic [19:0] gsel = {5'h10, 5'h02, 5'h01, 5'h00};
  logic [3:0] gen = 4'hf;
  logic [1:0] dflt = 2'h2;
  logic [15:0] mot_cur = 16'h0100;
  logic [15:0] nom_cur = 16'h0100;
  logic mot_var = 1'b0;
  logic mot_only = 1'b0;
  logic lt = 1'b0;
  logic arc = 1'b0;
  logic fstart = 1'b0;
  logic ftrip = 1'b0;
  logic [1:0] active_group;
  logic [1:0] stage_status;
  logic start_out;
  logic trip_out;
  logic force_flag;
  int fails = 0;
  int compares = 0;
  int n;
  // group cases: pins, virtual, order, expected group
  logic [15:0] gdi [5] = '{16'h0, 16'h2, 16'h6, 16'h6, 16'h0};
  logic [3:0] gvi [5] = '{4'h0, 4'h0, 4'h0, 4'h0, 4'h1};
  logic gord [5] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0};
  logic [1:0] gexp [5] = '{2'h2, 2'h1, 2'h1, 2'h2, 2'h3};

  // 100 MHz clock
  always #5 core_clk = ~core_clk;

  psc_far_side u_far (
    .core_clk(core_clk), .fault_on(fault_on), .pins_req(pins_req),
    .measured(measured), .digital_input(digital_input)
  );

  // all groups alike: 20 cycle operate, 10 cycle reset delay
  psc_stage #(.force_cycles(1000)) u_dut (
    .core_clk(core_clk), .rst(rst), .digital_input(digital_input), .virtual_input(vi),
    .group_control_input_select(gsel),
    .group_control_enable(gen), .default_group_select(dflt), .group_priority_order(ord),
    .pickup_pu({4{16'h0100}}), .hyst_pu({4{16'h0010}}), .operate_delay({4{32'h14}}),
    .reset_delay({4{32'h0a}}), .measured(measured), .motor_rated_current(mot_cur),
    .nominal_current(nom_cur), .motor_variant(mot_var), .motor_only(mot_only),
    .less_than(lt), .arc_stage(arc), .block_in(block_in), .latch_enable(latch_enable),
    .latch_release(latch_release), .force_set(force_set), .force_start(fstart),
    .force_trip(ftrip), .panel_button(panel_button), .active_group(active_group),
    .stage_status(stage_status), .start_out(start_out), .trip_out(trip_out),
    .force_flag(force_flag)
  );

  // one comparison, counted
  task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  // bounded wait: 0 start, 1 trip, 2 force flag reaching lvl
  task automatic wait_for(input int which, input logic lvl, output int cnt);
    logic s;
    cnt = 0;
    do begin
      @(posedge core_clk);
      #1;
      cnt++;
      s = (which == 0) ? start_out : (which == 1) ? trip_out : force_flag;
    end while (s !== lvl && cnt < 2000);
  endtask

  // verdict and end of run
  task automatic close_out();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // watchdog: the sequence needs about 1800 cycles
  initial begin
    repeat (10000) @(posedge core_clk);
    fails++;
    close_out();
  end

  // main sequence
  initial begin
    repeat (16) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    #1;
    check("idle after reset", {start_out, trip_out, stage_status}, 4'h0);
    // group selection table, both priority orders
    for (int i = 0; i < 5; i++) begin
      @(posedge core_clk);
      pins_req <= gdi[i];
      vi <= gvi[i];
      ord <= gord[i];
      repeat (8) @(posedge core_clk);
      #1;
      check("active group", active_group, gexp[i]);
    end
    // fault, trip, then block after trip
    @(posedge core_clk) fault_on <= 1'b1;
    wait_for(0, 1'b1, n);
    check("start status", {n <= 4, stage_status}, {1'b1, psc_start});
    wait_for(1, 1'b1, n);
    check("trip delay", n >= 17 && n <= 23, 1'b1);
    @(posedge core_clk) block_in <= 1'b1;
    repeat (30) @(posedge core_clk);
    #1;
    check("trip under block", {trip_out, stage_status}, {1'b1, psc_trip});
    @(posedge core_clk) fault_on <= 1'b0;
    wait_for(1, 1'b0, n);
    check("release delay", n >= 8 && n <= 16, 1'b1);
    check("idle again", {start_out, stage_status}, 3'h0);
    // blocked stage sees fault but does not pick up
    @(posedge core_clk) fault_on <= 1'b1;
    repeat (10) @(posedge core_clk);
    #1;
    check("blocked", {start_out, stage_status}, {1'b0, psc_blocked});
    // fault vanishing early never trips
    @(posedge core_clk) block_in <= 1'b0;
    repeat (10) @(posedge core_clk);
    fault_on <= 1'b0;
    repeat (40) @(posedge core_clk);
    #1;
    check("no trip on short fault", trip_out, 1'b0);
    // block in mid delay freezes the count; latch armed before the trip it holds
    @(posedge core_clk);
    fault_on <= 1'b1;
    latch_enable <= 1'b1;
    wait_for(0, 1'b1, n);
    repeat (7) @(posedge core_clk);
    block_in <= 1'b1;
    repeat (25) @(posedge core_clk);
    #1;
    check("frozen no trip", trip_out, 1'b0);
    @(posedge core_clk) block_in <= 1'b0;
    wait_for(1, 1'b1, n);
    check("frozen remainder", n >= 8 && n <= 18, 1'b1);
    // latched trip survives fault clearance until released
    @(posedge core_clk);
    fault_on <= 1'b0;
    repeat (40) @(posedge core_clk);
    #1;
    check("latched trip", trip_out, 1'b1);
    @(posedge core_clk) latch_release <= 1'b1;
    @(posedge core_clk) latch_release <= 1'b0;
    wait_for(1, 1'b0, n);
    check("latch release", n <= 16, 1'b1);
    // force flag timeout restarts on panel activity
    @(posedge core_clk) force_set <= 1'b1;
    @(posedge core_clk) force_set <= 1'b0;
    repeat (500) @(posedge core_clk);
    #1;
    check("force flag set", force_flag, 1'b1);
    @(posedge core_clk) panel_button <= 1'b1;
    wait_for(2, 1'b0, n);
    check("force timeout", n >= 990 && n <= 1010, 1'b1);
    close_out();
  end
endmodule // protection_stage_control_tb_top
`default_nettype wire
